// [hdl/arp_pkg.sv]
// Purpose: Shared constants and types for the converter result output port.
// Assumes: 250 MHz system clock; 16-bit results.
// Notes:   Pin indices name the shared data-bus pins by their serial use.

package arp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int RES_W      = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_RESULT = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CTRL   = 8'h08;
    localparam int CTRL_EN_BIT   = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_NEMPTY_BIT = 0;
    localparam int ST_FULL_BIT   = 1;
    localparam int ST_FRAME_BIT  = 2;
    localparam int ST_SERIAL_BIT = 3;
    localparam int ST_SLAVE_BIT  = 4;

    // ------------------------------------------------------------------
    // Shared pin positions in serial mode
    // ------------------------------------------------------------------
    localparam int PIN_DIV_LO = 2;
    localparam int PIN_DIV_HI = 3;
    localparam int PIN_EXT    = 4;
    localparam int PIN_SYNCPOL = 5;
    localparam int PIN_INVCLK = 6;
    localparam int PIN_RDCHN  = 7;
    localparam int PIN_SDO    = 8;
    localparam int PIN_SCLK   = 9;
    localparam int PIN_SYNC   = 10;
    localparam int PIN_ERR    = 11;

    // ------------------------------------------------------------------
    // Timing: internal serial clock quarter period
    // ------------------------------------------------------------------
    localparam int CLK_NS = 4;
    localparam int QTR_NS = 8;
    localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam logic [4:0] SLV_DONE = 5'h10;

    // ------------------------------------------------------------------
    // Master sequencer states (Gray along idle, shift, gap)
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP   = 2'b11
    } arp_state_t;

    // Straight binary when select high, MSB flipped otherwise
    function automatic logic [RES_W-1:0] arp_format(input logic [RES_W-1:0] raw,
                                                    input logic            straight);
        arp_format = {raw[RES_W-1] ^ ~straight, raw[RES_W-2:0]};
    endfunction

endpackage

// [hdl/arp_fifo.sv]
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock; depth is a power of two.
// Notes:   Full and empty are exact; a push on a full FIFO is refused.
`timescale 1ns/1ps

module arp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW:0]      count_r;
    wire              do_push;
    wire              do_pop;

    // ------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------
    assign in_ready  = (count_r != (PW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;

    // Storage has no reset; only pointers and fill level need a defined start
    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + PW'(do_push);
            rd_ptr_r <= rd_ptr_r + PW'(do_pop);
            count_r  <= count_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

endmodule

// [hdl/arp_clkdiv.sv]
// Purpose: Tick generator for the internal serial clock quarter phases.
// Assumes: Divider select is stable during a frame.
// Notes:   Slow selection stretches the quarter period by 1, 2, 4 or 8.
`timescale 1ns/1ps

module arp_clkdiv (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       en,
    input  wire logic       slow,
    input  wire logic [1:0] div,
    output logic            tick
);
    logic [7:0] cnt_r;
    wire  [1:0] shift_sel;
    wire  [7:0] limit;

    // Divider honoured only when asked to slow
    assign shift_sel = slow ? div : 2'b00;
    assign limit     = (8'(arp_pkg::QTR_CYC) << shift_sel) - 8'h01;
    assign tick      = en & (cnt_r == limit);

    // Counter restarts each frame so the first quarter is full length
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= (!en || tick) ? 8'h00 : cnt_r + 8'h01;
        end
    end

    base_rate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (tick && !slow) ##1 (en && !slow) [*2] |-> tick)
        else $error("quarter tick not at base rate when divider ignored");

endmodule

// [hdl/arp_port.sv]
// Purpose: Result output port: parallel bus or serial port on shared pins.
// Assumes: Pin inputs synchronous to sys_clk; conv_busy high while converting.
// Notes:   Results enter through a register write and wait in an 8-word FIFO.
//
// How it works
// - Serial select low gives parallel bus
// - Serial mode floats bits 0 and 1
// - Shared pins: data bit or serial function
// - Divider used only in master read-after-convert
// - Clock source: drive internal or accept external
// - Sync polarity pin sets frame-sync active level
// - Clock invert pin flips serial clock
// - Chain input emerges after sixteen clock periods
// - Master read during or after conversion
// - Shift register sends MSB first
// - Format pin chooses output number format
// - Master data stable across both clock edges
// - Format high straight binary, low flips MSB
// - Slave updates data on rising edge
// - Master holds sync active while data valid
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

module arp_port (
    input  wire logic                         sys_clk,
    input  wire logic                         resetn,
    input  wire logic [arp_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [arp_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [arp_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic                         serial_select,
    input  wire logic                         output_format_select,
    input  wire logic                         conv_busy,
    input  wire logic [arp_pkg::RES_W-1:0]    d_i,
    output logic      [arp_pkg::RES_W-1:0]    d_o,
    output logic      [arp_pkg::RES_W-1:0]    d_oe,
    output logic                              result_ready
);
    localparam int W = arp_pkg::RES_W;

    // ------------------------------------------------------------------
    // Serial-mode pin functions
    // ------------------------------------------------------------------
    wire       clock_source_select;
    wire       frame_sync_polarity;
    wire       serial_clock_invert;
    wire       read_mode_or_chain_input;
    wire [1:0] internal_clock_divider;
    wire       sclk_in;

    // Inputs on shared pins only meaningful in serial mode
    assign clock_source_select      = d_i[arp_pkg::PIN_EXT];
    assign frame_sync_polarity      = d_i[arp_pkg::PIN_SYNCPOL];
    assign serial_clock_invert      = d_i[arp_pkg::PIN_INVCLK];
    assign read_mode_or_chain_input = d_i[arp_pkg::PIN_RDCHN];
    assign internal_clock_divider   = d_i[arp_pkg::PIN_DIV_HI:arp_pkg::PIN_DIV_LO];
    assign sclk_in                  = d_i[arp_pkg::PIN_SCLK];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    arp_pkg::arp_state_t st_r;
    arp_pkg::arp_state_t st_nxt;
    logic [W-1:0] shift_r;
    logic [W-1:0] shift_nxt;
    logic [W-1:0] par_r;
    logic [3:0]   bit_r;
    logic [3:0]   bit_nxt;
    logic [1:0]   q_r;
    logic         sclk_act_r;
    logic         sclk_act_nxt;
    logic         sclk_r;
    logic         sync_r;
    logic         en_r;
    logic         busy_prev_r;
    logic         sclk_prev_r;
    logic [4:0]   slv_cnt_r;
    logic [arp_pkg::DATA_W-1:0] rdata_r;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    wire ser_mode;
    wire mst_mode;
    wire slv_mode;
    wire slow_sel;

    assign ser_mode = serial_select;
    assign mst_mode = ser_mode & ~clock_source_select;
    assign slv_mode = ser_mode & clock_source_select;
    assign slow_sel = mst_mode & ~read_mode_or_chain_input;

    // ------------------------------------------------------------------
    // Result FIFO
    // ------------------------------------------------------------------
    wire [W-1:0] fifo_data;
    wire         fifo_valid;
    wire         fifo_pop;
    wire         push_req;
    wire         push_ready;

    assign push_req     = reg_wr & (reg_addr == arp_pkg::OFS_RESULT);
    assign result_ready = push_ready;

    // A write while full is dropped; software sees it in the full flag
    arp_fifo #(
        .WIDTH (W),
        .DEPTH (arp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_data   (reg_wdata[W-1:0]),
        .in_valid  (push_req),
        .in_ready  (push_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ------------------------------------------------------------------
    // Internal serial clock ticks
    // ------------------------------------------------------------------
    wire tick;

    arp_clkdiv u_div (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .en      (st_r != arp_pkg::ST_IDLE),
        .slow    (slow_sel),
        .div     (internal_clock_divider),
        .tick    (tick)
    );

    // ------------------------------------------------------------------
    // Transfer triggers
    // ------------------------------------------------------------------
    wire rd_phase_ok;
    wire start_m;
    wire busy_fall;
    wire load_s;
    wire par_pop;
    wire sclk_norm;
    wire upd_edge;
    wire shift_m;
    wire shift_s;
    wire chain_bit;
    wire [W-1:0] fmt_word;

    // Read-during needs a conversion running, read-after needs it finished
    assign rd_phase_ok = read_mode_or_chain_input ? conv_busy : ~conv_busy;
    assign start_m     = en_r & mst_mode & fifo_valid & rd_phase_ok
                       & (st_r == arp_pkg::ST_IDLE);
    assign busy_fall   = busy_prev_r & ~conv_busy;
    // Slave takes the new word when the conversion ends, like a data latch
    assign load_s      = en_r & slv_mode & fifo_valid & busy_fall;
    assign par_pop     = en_r & ~ser_mode & fifo_valid;
    assign fifo_pop    = start_m | load_s | par_pop;
    assign fmt_word    = arp_pkg::arp_format(fifo_data, output_format_select);

    // External clock normalised so the update edge is always a rise
    assign sclk_norm = sclk_in ^ serial_clock_invert;
    assign upd_edge  = slv_mode & sclk_norm & ~sclk_prev_r;
    assign shift_m   = (st_r == arp_pkg::ST_SHIFT) & tick & (q_r == 2'b11)
                     & (bit_r != arp_pkg::LAST_BIT);
    assign shift_s   = upd_edge & ~load_s;
    assign chain_bit = slv_mode & read_mode_or_chain_input;

    // Load MSB-first word, then move one bit toward the output per clock
    assign shift_nxt = (start_m | load_s) ? fmt_word :
                       (shift_m | shift_s) ? {shift_r[W-2:0], chain_bit} :
                       shift_r;

    // ------------------------------------------------------------------
    // Master sequencer: four quarters per bit, data moves in quarter 3
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        bit_nxt      = bit_r;
        sclk_act_nxt = sclk_act_r;
        unique case (st_r)
            arp_pkg::ST_IDLE: begin
                sclk_act_nxt = 1'b0;
                if (start_m) begin
                    st_nxt  = arp_pkg::ST_SHIFT;
                    bit_nxt = 4'h0;
                end
            end
            arp_pkg::ST_SHIFT: begin
                if (tick) begin
                    // Edges sit mid-bit so either edge samples safely
                    if (q_r == 2'b00) begin
                        sclk_act_nxt = 1'b1;
                    end
                    if (q_r == 2'b10) begin
                        sclk_act_nxt = 1'b0;
                    end
                    if (q_r == 2'b11) begin
                        if (bit_r == arp_pkg::LAST_BIT) begin
                            st_nxt = arp_pkg::ST_GAP;
                        end else begin
                            bit_nxt = bit_r + 4'h1;
                        end
                    end
                end
            end
            arp_pkg::ST_GAP: begin
                if (tick) begin
                    st_nxt = arp_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = arp_pkg::ST_IDLE;
            end
        endcase
        // Leaving master mode aborts the frame at once
        if (!mst_mode) begin
            st_nxt       = arp_pkg::ST_IDLE;
            sclk_act_nxt = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r       <= arp_pkg::ST_IDLE;
            bit_r      <= 4'h0;
            q_r        <= 2'b00;
            sclk_act_r <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            bit_r      <= bit_nxt;
            q_r        <= (st_nxt != arp_pkg::ST_SHIFT) ? 2'b00 : q_r + 2'(tick);
            sclk_act_r <= sclk_act_nxt;
        end
    end

    // Pin-side registers: clock level, frame sync, shifter, parallel word
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_r  <= 1'b0;
            sync_r  <= 1'b0;
            shift_r <= '0;
            par_r   <= '0;
        end else begin
            sclk_r  <= sclk_act_nxt ^ serial_clock_invert;
            sync_r  <= ((st_nxt == arp_pkg::ST_SHIFT) & mst_mode)
                       ^ frame_sync_polarity;
            shift_r <= shift_nxt;
            par_r   <= par_pop ? fmt_word : par_r;
        end
    end

    // Slave bit counter saturates once the chained bits start arriving
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            slv_cnt_r   <= arp_pkg::SLV_DONE;
            busy_prev_r <= 1'b0;
            sclk_prev_r <= 1'b0;
        end else begin
            busy_prev_r <= conv_busy;
            sclk_prev_r <= sclk_norm;
            if (load_s) begin
                slv_cnt_r <= 5'h00;
            end else if (shift_s && slv_cnt_r != arp_pkg::SLV_DONE) begin
                slv_cnt_r <= slv_cnt_r + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive: parallel word or serial functions on shared pins
    // ------------------------------------------------------------------
    logic [W-1:0] ser_o;
    logic [W-1:0] ser_oe;

    always_comb begin
        ser_o  = par_r;
        ser_oe = {W{1'b1}};
        ser_oe[1:0] = 2'b00;
        ser_oe[arp_pkg::PIN_RDCHN:arp_pkg::PIN_DIV_LO] = '0;
        ser_o[arp_pkg::PIN_SDO]   = shift_r[W-1];
        ser_o[arp_pkg::PIN_SCLK]  = sclk_r;
        ser_oe[arp_pkg::PIN_SCLK] = mst_mode;
        ser_o[arp_pkg::PIN_SYNC]  = sync_r;
        ser_o[arp_pkg::PIN_ERR]   = 1'b0;
    end

    // Mux of flopped values keeps serial timing free of an extra stage
    assign d_o  = ser_mode ? ser_o : par_r;
    assign d_oe = ser_mode ? ser_oe : {W{1'b1}};

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    wire [arp_pkg::DATA_W-1:0] status_word;
    wire [arp_pkg::DATA_W-1:0] rd_mux;

    assign status_word = {27'h000_0000, slv_mode, ser_mode,
                          (st_r != arp_pkg::ST_IDLE), ~push_ready, fifo_valid};
    assign rd_mux = (reg_addr == arp_pkg::OFS_RESULT) ? {16'h0000, par_r} :
                    (reg_addr == arp_pkg::OFS_STATUS) ? status_word :
                    (reg_addr == arp_pkg::OFS_CTRL)   ? {31'h0000_0000, en_r} :
                    32'h0000_0000;
    assign reg_rdata = rdata_r;

    // Read data stands for exactly one cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            en_r    <= arp_pkg::CTRL_EN_RST;
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
            if (reg_wr && reg_addr == arp_pkg::OFS_CTRL) begin
                en_r <= reg_wdata[arp_pkg::CTRL_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_start;
        start_m;
    endsequence

    sequence s_frame_open;
        (st_r == arp_pkg::ST_SHIFT);
    endsequence

    par_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !serial_select |-> (d_oe == 16'hFFFF) && (d_o == par_r))
        else $error("parallel mode does not drive the whole bus");

    low_float_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        serial_select |-> (d_oe[1:0] == 2'b00))
        else $error("low data bits driven in serial mode");

    clk_dir_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        serial_select |-> (d_oe[arp_pkg::PIN_SCLK] == !clock_source_select))
        else $error("serial clock pin direction wrong");

    sync_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_start ##0 mst_mode ##1 s_frame_open ##1 $stable(frame_sync_polarity)
        |-> d_o[arp_pkg::PIN_SYNC] == !frame_sync_polarity)
        else $error("frame sync not at active level during frame");

    idle_clk_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (mst_mode && st_r == arp_pkg::ST_IDLE && $past(st_r) == arp_pkg::ST_IDLE
         && $stable(serial_clock_invert)) |-> sclk_r == serial_clock_invert)
        else $error("idle serial clock level ignores invert");

    chain_in_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        shift_s |=> shift_r[0] == $past(read_mode_or_chain_input))
        else $error("chain input not shifted into the register");

    rd_phase_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        start_m |-> conv_busy == read_mode_or_chain_input)
        else $error("master read started in wrong conversion phase");

    msb_first_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        start_m |=> d_o[arp_pkg::PIN_SDO] == $past(fmt_word[W-1]) || !serial_select)
        else $error("first serial bit is not the MSB");

    edge_stable_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_r == arp_pkg::ST_SHIFT && $changed(sclk_act_r)) |-> $stable(shift_r))
        else $error("data moved on an internal clock edge");

    fmt_msb_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        par_pop |=> par_r[W-1] == ($past(fifo_data[W-1]) ^ !$past(output_format_select)))
        else $error("result MSB format wrong");

    slave_edge_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        shift_s |=> shift_r[W-1] == $past(shift_r[W-2]))
        else $error("slave data not moved on update edge");

    sixteen_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_r == arp_pkg::ST_SHIFT && st_nxt == arp_pkg::ST_GAP) |-> bit_r == 4'hF)
        else $error("frame ended without sixteen bits");

endmodule

// [sim/arp_host_model.sv]
// Purpose: Host model: drives serial mode pins, captures master frames.
// Assumes: Captures master frames; the bench drives the external clock.
// Notes:   Undriven pins toggle each cycle so stale levels never match.
`timescale 1ns/1ps

module arp_host_model (
    input  wire logic        sys_clk,
    input  wire logic        serial_select,
    input  wire logic        ext_sclk,
    input  wire logic [7:2]  pins,
    input  wire logic [15:0] d_o,
    output logic      [15:0] d_i,
    output logic      [15:0] rx_word,
    output logic      [4:0]  rx_cnt,
    output logic             rx_stb
);
    logic [15:0] junk_r = 16'h5a5a;
    logic [7:2]  pins_q = 6'h00;
    logic        sclk_q = 1'b0;
    logic        sync_q = 1'b0;
    // Device registers clock and sync from last cycle's pin levels
    wire         sclk_a = serial_select & (d_o[9] ^ pins_q[6]);
    wire         sync_a = serial_select & (d_o[10] ^ pins_q[5]);
    // Pin levels seen by the device; external clock from the bench
    assign d_i = {junk_r[15:10], ext_sclk, junk_r[8], pins, junk_r[1:0]};

    // Sample mid-bit on the active clock edge while sync is active
    always_ff @(posedge sys_clk) begin
        junk_r <= ~junk_r;
        pins_q <= pins;
        sclk_q <= sclk_a;
        sync_q <= sync_a;
        rx_stb <= sync_q & ~sync_a;
        if (sync_a & sclk_a & ~sclk_q) begin
            rx_word <= {rx_word[14:0], d_o[8]};
            rx_cnt  <= rx_cnt + 5'd1;
        end
        if (sync_a & ~sync_q)
            rx_cnt <= 5'd0;
    end
endmodule

// [sim/tb_arp_port.sv]
// Purpose: Self-checking bench for the result output port.
// Assumes: 250 MHz clock; host model on the serial side.
// Notes:   Serial frames are checked against a queue of expected words.
`timescale 1ns/1ps

module tb_arp_port;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        serial_select = 1'b0;
    logic        fmt = 1'b1;
    logic        conv_busy = 1'b0;
    logic [7:2]  pins = 6'h00;
    logic [31:0] reg_rdata;
    logic [15:0] d_i, d_o, d_oe, rx_word;
    logic [4:0]  rx_cnt;
    logic        rx_stb, result_ready;
    logic        ext_sclk = 1'b0;
    logic [15:0] ex_w;
    logic [31:0] lfsr = 32'h0f58_bdca;
    logic [15:0] exp_q[$];
    int          errors = 0;
    int          cmp_count = 0;
    always #2 sys_clk = ~sys_clk;

    arp_port dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_select(serial_select), .output_format_select(fmt), .conv_busy(conv_busy),
        .d_i(d_i), .d_o(d_o), .d_oe(d_oe), .result_ready(result_ready));
    arp_host_model host_u (.sys_clk(sys_clk), .serial_select(serial_select),
        .ext_sclk(ext_sclk), .pins(pins), .d_o(d_o), .d_i(d_i),
        .rx_word(rx_word), .rx_cnt(rx_cnt), .rx_stb(rx_stb));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Strobe for one cycle, then one idle cycle so no edge sees two drives
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("read data", exp, reg_rdata);
        @(posedge sys_clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Oldest expected word against each captured frame
    always @(posedge sys_clk) begin
        if (rx_stb === 1'b1) begin
            if (exp_q.size() == 0)
                chk("extra frame", 32'h0, 32'h1);
            else
                chk("serial word", {16'h0, exp_q.pop_front()}, {16'h0, rx_word});
            chk("bit count", 32'd16, {27'h0, rx_cnt});
        end
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        reg_read(8'h08, 32'h1);
        reg_read(8'h0c, 32'h0);
        $display("test registers done");
        for (int f = 0; f < 2; f++) begin
            fmt <= f[0];
            lfsr = lfsr_next(lfsr);
            reg_write(8'h00, {16'h0, lfsr[15:0]});
            #1 chk("parallel word", {16'h0, lfsr[15:0] ^ {~fmt, 15'h0}}, {16'h0, d_o});
            chk("parallel enables", 32'hffff, {16'h0, d_oe});
        end
        $display("test parallel done");
        // Fill while disabled, overflow once, then drain as master
        for (int r = 0; r < 2; r++) begin
            reg_write(8'h08, 32'h0);
            serial_select <= 1'b1;
            lfsr = lfsr_next(lfsr);
            pins <= {r[0], lfsr[6:5], 1'b0, lfsr[3:2]};
            conv_busy <= r[0];
            for (int i = 0; i < 9; i++) begin
                lfsr = lfsr_next(lfsr);
                if (i < 8)
                    exp_q.push_back(lfsr[15:0] ^ {~fmt, 15'h0});
                reg_write(8'h00, {16'h0, lfsr[15:0]});
            end
            #1 chk("ready when full", 32'h0, {31'h0, result_ready});
            chk("serial enables", 32'h0300, {16'h0, d_oe & 16'h03ff});
            reg_write(8'h08, 32'h1);
            for (int t = 0; t < 20000 && exp_q.size() > 0; t++)
                @(posedge sys_clk);
            repeat (2500) @(posedge sys_clk);
            chk("frames left", 32'h0, exp_q.size());
            if (exp_q.size() != 0)
                wrap_up();
            $display("test serial round %0d done", r);
        end
        // Slave: word goes out on the external clock, then the chained level
        lfsr = lfsr_next(lfsr);
        fmt <= lfsr[21];
        pins <= {lfsr[20:19], 4'b0100};
        ex_w = lfsr[15:0] ^ {~lfsr[21], 15'h0};
        reg_write(8'h00, {16'h0, lfsr[15:0]});
        conv_busy <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 18; i++) begin
            #1 chk("slave bit", {31'h0, ex_w[15]}, {31'h0, d_o[8]});
            ex_w = {ex_w[14:0], lfsr[20]};
            @(posedge sys_clk);
            ext_sclk <= 1'b1;
            repeat (2) @(posedge sys_clk);
            ext_sclk <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
        $display("test slave done");
        wrap_up();
    end
endmodule
